//--- design/ppc_power_cap.sv
// power-management capability block: config load, power states, wake event, registers
// assumes a host master on the plain register port and a serial config reader outside
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: skip bit set: software D3hot to D0 keeps context, no internal reset.
// R2: skip bit clear: software D3hot to D0 runs internal reset, context lost.
// R3: bus reset gives D0 uninitialized, keeping wake context only if supported and enabled.
// R4: skip bit copied into bit 3 of chip power control register.
// R5: D2 wake allowed only when D2 wake bit and wake enable set.
// R6: D2 wake bit copied to capabilities bit 13 and id word bit 29.
// R7: D1 wake allowed only when D1 wake bit and wake enable set.
// R8: D1 wake bit copied to capabilities bit 12 and id word bit 28.
// R9: D2 support bit enables D2 state, copied to bits 10 and 26.
// R10: capability list bit copied into command status capability flag.
// R11: capability list bit reports whether a new capability list exists.
// R12: load config word after reset before host reads; defaults without memory.
module ppc_power_cap #(
    parameter logic [ppc_pkg::CFG_W-1:0] CFG_RESET_WORD = ppc_pkg::CFG_DEFAULT,
    parameter int                        FETCH_TIMEOUT  = ppc_pkg::FETCH_TIMEOUT_CYC
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          bus_reset,
    input  wire logic [ppc_pkg::ADDR_W-1:0]    addr,
    input  wire logic [ppc_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic      [ppc_pkg::DATA_W-1:0]    rdata,
    input  wire logic                          cfg_present,
    output logic                               cfg_req,
    input  wire logic                          cfg_valid,
    input  wire logic [ppc_pkg::CFG_W-1:0]     cfg_data,
    output logic                               cfg_loaded,
    input  wire logic                          wake_event,
    output logic                               pme_request,
    output logic                               soft_reset,
    output logic      [1:0]                    power_state,
    output logic                               d0_initialized,
    output logic                               irq
);
    import ppc_pkg::*;

    ppc_state_t state_reg;
    ppc_state_t state_next;

    logic       wake_ok;
    logic       legal_ps;
    logic [1:0] new_ps;
    logic       pme_supported;
    logic [IRQ_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////////
    // state-dependent wake permission
    function automatic logic wake_allowed(input logic [1:0] ps, input logic [CFG_W-1:0] c);
        logic ok;
        ok = 1'b1;
        if (ps == PS_D1) begin
            ok = c[CFG_WAKE_D1_BIT]; // [R7]
        end else if (ps == PS_D2) begin
            ok = c[CFG_WAKE_D2_BIT]; // [R5]
        end
        return ok;
    endfunction : wake_allowed

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next    = state_reg;
        state_next.rdata = '0;
        ev            = '0;
        new_ps        = wdata[PCS_STATE_LSB +: PCS_STATE_W];
        legal_ps      = (new_ps == PS_D0) || (new_ps == PS_D3HOT)
                     || ((new_ps == PS_D1) && state_reg.cfg[CFG_D1_STATE_SUPPORTED_BIT])
                     || ((new_ps == PS_D2) && state_reg.cfg[CFG_D2_STATE_SUPPORTED_BIT]); // [R9]
        pme_supported = state_reg.cfg[CFG_WAKE_D1_BIT] || state_reg.cfg[CFG_WAKE_D2_BIT];
        wake_ok       = wake_allowed(state_reg.pstate, state_reg.cfg);

        // config load sequence
        unique case (state_reg.phase)
            PH_START: begin
                state_next.fetch_cnt = '0;
                if (cfg_present) begin
                    state_next.cfg_req = 1'b1;
                    state_next.phase   = PH_FETCH;
                end else begin
                    state_next.cfg   = CFG_RESET_WORD; // [R12]
                    state_next.phase = PH_RUN;
                    ev[EV_CFG_DONE]  = 1'b1;
                end
            end
            PH_FETCH: begin
                state_next.fetch_cnt = state_reg.fetch_cnt + 1'b1;
                if (cfg_valid) begin
                    state_next.cfg     = cfg_data; // [R12]
                    state_next.cfg_req = 1'b0;
                    state_next.phase   = PH_RUN;
                    ev[EV_CFG_DONE]    = 1'b1;
                end else if (state_reg.fetch_cnt == FETCH_CNT_W'(FETCH_TIMEOUT - 1)) begin
                    state_next.cfg     = CFG_RESET_WORD;
                    state_next.cfg_req = 1'b0;
                    state_next.phase   = PH_RUN;
                    ev[EV_CFG_DONE]    = 1'b1;
                end
            end
            PH_RUN: begin
                state_next.fetch_cnt = '0;
            end
            PH_SRST: begin
                if (state_reg.srst_cnt == '0) begin
                    state_next.phase = PH_START;
                end else begin
                    state_next.srst_cnt = state_reg.srst_cnt - 1'b1;
                end
            end
        endcase

        // host register writes, taken only once the config word is valid
        if (wr_en && state_reg.phase == PH_RUN) begin
            unique case (addr)
                OFF_PM_CTRL: begin
                    state_next.wake_event_enable = wdata[PCS_WAKE_EVENT_ENABLE_BIT];
                    if (wdata[PCS_PME_STAT_BIT]) begin
                        state_next.pme_stat = 1'b0;
                    end
                    if (legal_ps) begin
                        if (state_reg.pstate == PS_D3HOT && new_ps == PS_D0) begin
                            if (state_reg.cfg[CFG_SKIP_SRST_BIT]) begin
                                state_next.pstate = PS_D0; // [R1]
                            end else begin
                                state_next.pstate   = PS_D0; // [R2]
                                state_next.d0_init  = 1'b0;
                                state_next.irq_mask = '0;
                                state_next.wake_event_enable   = 1'b0;
                                state_next.pme_stat = 1'b0;
                                state_next.cfg_req  = 1'b0;
                                state_next.srst_cnt = SRST_CNT_W'(SRST_CYCLES - 1);
                                state_next.phase    = PH_SRST;
                                ev[EV_SOFT_RST]     = 1'b1;
                            end
                        end else begin
                            state_next.pstate = new_ps;
                        end
                    end
                end
                OFF_CHIP_PMC: begin
                    if (state_reg.pstate == PS_D0) begin
                        state_next.d0_init = wdata[CPM_INIT_DONE_BIT];
                    end
                end
                OFF_IRQ_STAT: begin
                    state_next.irq_stat = state_reg.irq_stat & ~wdata[IRQ_W-1:0];
                end
                OFF_IRQ_MASK: begin
                    state_next.irq_mask = wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // wake events; set wins over a clear in the same cycle
        if (wake_event && state_reg.wake_event_enable && wake_ok && state_reg.phase == PH_RUN) begin
            state_next.pme_stat = 1'b1; // [R5] [R7]
            ev[EV_PME]          = 1'b1;
        end

        // bus segment reset: back to D0 uninitialized, reload config
        if (bus_reset) begin
            state_next.phase    = PH_START; // [R3]
            state_next.pstate   = PS_D0;
            state_next.d0_init  = 1'b0;
            state_next.cfg_req  = 1'b0;
            state_next.srst_cnt = '0;
            state_next.wake_event_enable   = pme_supported && state_reg.wake_event_enable; // [R3]
            state_next.pme_stat = pme_supported && state_reg.wake_event_enable && state_reg.pme_stat;
            ev                  = '0;
            ev[EV_BUS_RST]      = 1'b1;
        end

        state_next.irq_stat = state_next.irq_stat | ev;
        state_next.srst     = (state_next.phase == PH_SRST);

        // register reads, answered the following cycle
        if (rd_en) begin
            unique case (addr)
                OFF_CFG_WORD: begin
                    state_next.rdata[CFG_W-1:0] = state_reg.cfg; // [R11]
                end
                OFF_CFG_CMD_ST: begin
                    state_next.rdata[CCS_CAP_LIST_BIT] = state_reg.cfg[CFG_CAP_LIST_BIT]; // [R10]
                end
                OFF_CAP_ID: begin
                    state_next.rdata[CID_WAKE_D2_BIT] = state_reg.cfg[CFG_WAKE_D2_BIT]; // [R6]
                    state_next.rdata[CID_WAKE_D1_BIT] = state_reg.cfg[CFG_WAKE_D1_BIT]; // [R8]
                    state_next.rdata[CID_D2_STATE_SUPPORTED_BIT]  = state_reg.cfg[CFG_D2_STATE_SUPPORTED_BIT];  // [R9]
                    state_next.rdata[CID_D1_STATE_SUPPORTED_BIT]  = state_reg.cfg[CFG_D1_STATE_SUPPORTED_BIT];
                end
                OFF_PM_CAP: begin
                    state_next.rdata[PMC_WAKE_D2_BIT] = state_reg.cfg[CFG_WAKE_D2_BIT]; // [R6]
                    state_next.rdata[PMC_WAKE_D1_BIT] = state_reg.cfg[CFG_WAKE_D1_BIT]; // [R8]
                    state_next.rdata[PMC_D2_STATE_SUPPORTED_BIT]  = state_reg.cfg[CFG_D2_STATE_SUPPORTED_BIT];  // [R9]
                    state_next.rdata[PMC_D1_STATE_SUPPORTED_BIT]  = state_reg.cfg[CFG_D1_STATE_SUPPORTED_BIT];
                end
                OFF_PM_CTRL: begin
                    state_next.rdata[PCS_STATE_LSB +: PCS_STATE_W] = state_reg.pstate;
                    state_next.rdata[PCS_WAKE_EVENT_ENABLE_BIT]   = state_reg.wake_event_enable;
                    state_next.rdata[PCS_PME_STAT_BIT] = state_reg.pme_stat;
                end
                OFF_CHIP_PMC: begin
                    state_next.rdata[CPM_SKIP_SRST_BIT] = state_reg.cfg[CFG_SKIP_SRST_BIT]; // [R4]
                    state_next.rdata[CPM_INIT_DONE_BIT] = state_reg.d0_init;
                end
                OFF_IRQ_STAT: begin
                    state_next.rdata[IRQ_W-1:0] = state_reg.irq_stat;
                end
                OFF_IRQ_MASK: begin
                    state_next.rdata[IRQ_W-1:0] = state_reg.irq_mask;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '{phase: PH_START, pstate: PS_D0, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata          = state_reg.rdata;
    assign cfg_req        = state_reg.cfg_req;
    assign cfg_loaded     = (state_reg.phase == PH_RUN);
    assign soft_reset     = state_reg.srst;
    assign power_state    = state_reg.pstate;
    assign d0_initialized = state_reg.d0_init;
    assign pme_request    = state_reg.pme_stat && state_reg.wake_event_enable && wake_ok; // [R5] [R7]
    assign irq            = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule : ppc_power_cap

`default_nettype wire

//--- design/ppc_pkg.sv
// constants, register map and state type of the power-management capability block
// assumes a 20 MHz clock and a word-aligned plain register port
package ppc_pkg;

    // bus and word widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CFG_W  = 16;
    localparam int IRQ_W  = 4;

    // timing
    localparam int CLK_PERIOD_NS       = 50;
    localparam int SRST_TIME_NS        = 1000;
    localparam int SRST_CYCLES         = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRST_CNT_W          = $clog2(SRST_CYCLES + 1);
    localparam int FETCH_TIMEOUT_CYC   = 4096;
    localparam int FETCH_CNT_W         = 13;

    // configuration word fields
    localparam int CFG_CAP_LIST_BIT    = 15;
    localparam int CFG_SKIP_SRST_BIT   = 14;
    localparam int CFG_WAKE_D2_BIT     = 12;
    localparam int CFG_WAKE_D1_BIT     = 11;
    localparam int CFG_D2_STATE_SUPPORTED_BIT      = 10;
    localparam int CFG_D1_STATE_SUPPORTED_BIT      = 9;
    localparam logic [CFG_W-1:0] CFG_DEFAULT = 16'h0000;

    // copies of configuration fields in the capability registers
    localparam int PMC_WAKE_D2_BIT     = 13;
    localparam int PMC_WAKE_D1_BIT     = 12;
    localparam int PMC_D2_STATE_SUPPORTED_BIT      = 10;
    localparam int PMC_D1_STATE_SUPPORTED_BIT      = 9;
    localparam int CID_WAKE_D2_BIT     = 29;
    localparam int CID_WAKE_D1_BIT     = 28;
    localparam int CID_D2_STATE_SUPPORTED_BIT      = 26;
    localparam int CID_D1_STATE_SUPPORTED_BIT      = 25;
    localparam int CCS_CAP_LIST_BIT    = 20;
    localparam int CPM_SKIP_SRST_BIT   = 3;
    localparam int CPM_INIT_DONE_BIT   = 0;

    // power control and status fields
    localparam int PCS_STATE_LSB       = 0;
    localparam int PCS_STATE_W         = 2;
    localparam int PCS_WAKE_EVENT_ENABLE_BIT      = 8;
    localparam int PCS_PME_STAT_BIT    = 15;
    localparam logic [1:0] PS_D0       = 2'h0;
    localparam logic [1:0] PS_D1       = 2'h1;
    localparam logic [1:0] PS_D2       = 2'h2;
    localparam logic [1:0] PS_D3HOT    = 2'h3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CFG_WORD   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CFG_CMD_ST = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CAP_ID     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PM_CAP     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PM_CTRL    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CHIP_PMC   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h1C;

    // interrupt event bits
    localparam int EV_PME      = 0;
    localparam int EV_SOFT_RST = 1;
    localparam int EV_CFG_DONE = 2;
    localparam int EV_BUS_RST  = 3;

    typedef enum logic [1:0] {PH_START, PH_FETCH, PH_RUN, PH_SRST} ppc_phase_t;

    typedef struct packed {
        ppc_phase_t              phase;
        logic [CFG_W-1:0]        cfg;
        logic [1:0]              pstate;
        logic                    d0_init;
        logic                    wake_event_enable;
        logic                    pme_stat;
        logic [IRQ_W-1:0]        irq_stat;
        logic [IRQ_W-1:0]        irq_mask;
        logic [SRST_CNT_W-1:0]   srst_cnt;
        logic [FETCH_CNT_W-1:0]  fetch_cnt;
        logic                    srst;
        logic                    cfg_req;
        logic [DATA_W-1:0]       rdata;
    } ppc_state_t;

endpackage : ppc_pkg

//--- tb/ppc_cap_mon_monitor.sv
// checker for the power capability block, ports only
// bound onto ppc_power_cap from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module ppc_cap_mon #(
    parameter logic [ppc_pkg::CFG_W-1:0] CFG_RESET_WORD = ppc_pkg::CFG_DEFAULT
) (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire logic                       bus_reset,
    input wire logic [ppc_pkg::ADDR_W-1:0] addr,
    input wire logic                       rd_en,
    input wire logic [ppc_pkg::DATA_W-1:0] rdata,
    input wire logic                       cfg_req,
    input wire logic                       cfg_valid,
    input wire logic [ppc_pkg::CFG_W-1:0]  cfg_data,
    input wire logic                       cfg_loaded,
    input wire logic                       pme_request,
    input wire logic                       soft_reset,
    input wire logic [1:0]                 power_state,
    input wire logic                       d0_initialized
);
    import ppc_pkg::*;
    logic [CFG_W-1:0]  cfg_w, w_q;
    logic [ADDR_W-1:0] addr_q;
    logic              rd_q;
    logic [7:0]        srst_n;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the loaded word, delayed read request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_w  <= CFG_RESET_WORD;
            rd_q   <= 1'b0;
            srst_n <= 8'h00;
        end else begin
            if (bus_reset || soft_reset) cfg_w <= CFG_RESET_WORD;
            else if (cfg_valid && cfg_req) cfg_w <= cfg_data;
            rd_q   <= rd_en && cfg_loaded && !bus_reset;
            srst_n <= soft_reset ? srst_n + 8'h01 : 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        addr_q <= addr;
        w_q    <= cfg_w;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (reset);
    a_skip_copy: assert property (rd_q && addr_q == OFF_CHIP_PMC |->
        rdata[3] == w_q[14]) else $error("skip copy wrong");
    a_pmcap_copy: assert property (rd_q && addr_q == OFF_PM_CAP |->
        rdata[13] == w_q[12] && rdata[12] == w_q[11] && rdata[10] == w_q[10])
        else $error("capability copy wrong");
    a_capid_copy: assert property (rd_q && addr_q == OFF_CAP_ID |->
        rdata[29] == w_q[12] && rdata[28] == w_q[11] && rdata[26] == w_q[10])
        else $error("id word copy wrong");
    a_caplist_copy: assert property (rd_q && addr_q == OFF_CFG_CMD_ST |->
        rdata[20] == w_q[15]) else $error("list flag copy wrong");
    a_cfg_word: assert property (rd_q && addr_q == OFF_CFG_WORD |->
        rdata[15:0] == w_q) else $error("config word wrong");
    a_cfg_taken: assert property (cfg_valid && cfg_req && !bus_reset |=> cfg_loaded)
        else $error("config word not taken");
    a_no_d1_wake: assert property (power_state == PS_D1 && !cfg_w[11] |-> !pme_request)
        else $error("wake in D1 not allowed");
    a_no_d2_wake: assert property (power_state == PS_D2 && !cfg_w[12] |-> !pme_request)
        else $error("wake in D2 not allowed");
    a_skip_keeps: assert property ($past(power_state) == PS_D3HOT && power_state == PS_D0
        && !$past(bus_reset) && cfg_w[14] |-> !soft_reset
        && d0_initialized == $past(d0_initialized)) else $error("context not kept");
    a_srst_wake: assert property ($past(power_state) == PS_D3HOT && power_state == PS_D0
        && !$past(bus_reset) && !cfg_w[14] |-> soft_reset && !d0_initialized)
        else $error("no internal reset");
    a_srst_len: assert property ($fell(soft_reset) && !$past(reset)
        && !$past(bus_reset) |-> srst_n == SRST_CYCLES) else $error("soft reset length wrong");
    a_bus_rst: assert property (bus_reset |=> power_state == PS_D0 && !d0_initialized)
        else $error("bus reset state wrong");
endmodule : ppc_cap_mon
`default_nettype wire

//--- tb/ppc_cfg_mem.sv
// serial config memory model answering word requests
// drives the config port of ppc_power_cap; delay 15 answers after 16 request cycles, past the bench's fetch timeout
`timescale 1ns/10ps
`default_nettype none
module ppc_cfg_mem (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      cfg_req,
    input  wire logic [ppc_pkg::CFG_W-1:0] word,
    input  wire logic [3:0]                delay,
    output logic                           cfg_valid,
    output logic      [ppc_pkg::CFG_W-1:0] cfg_data
);
    import ppc_pkg::*;
    logic [3:0] cnt;
    // word only beside valid, else inverted
    assign cfg_data = cfg_valid ? word : ~word;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt       <= 4'h0;
            cfg_valid <= 1'b0;
        end else begin
            cfg_valid <= cfg_req && !cfg_valid && cnt == delay;
            cnt       <= (cfg_req && !cfg_valid) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule : ppc_cfg_mem
`default_nettype wire

//--- tb/tb_top.sv
// testbench top: register tasks, config model, checker bind
// runs ppc_power_cap alone at 20 MHz with a short fetch timeout
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ppc_pkg::*;
    logic              clk, reset, bus_reset, wr_en, rd_en, cfg_present, wake_event;
    logic              cfg_req, cfg_valid, cfg_loaded, pme_request, soft_reset;
    logic              d0_initialized, irq;
    logic [1:0]        power_state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [CFG_W-1:0]  cfg_data, mem_word;
    logic [3:0]        mem_delay;
    int                fails, num_checks, n;
    ppc_power_cap #(.FETCH_TIMEOUT(8)) ppc_power_cap_inst (
        .clk(clk), .reset(reset), .bus_reset(bus_reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cfg_present(cfg_present),
        .cfg_req(cfg_req), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
        .cfg_loaded(cfg_loaded), .wake_event(wake_event), .pme_request(pme_request),
        .soft_reset(soft_reset), .power_state(power_state),
        .d0_initialized(d0_initialized), .irq(irq));
    ppc_cfg_mem ppc_cfg_mem_inst (.clk(clk), .reset(reset), .cfg_req(cfg_req),
        .word(mem_word), .delay(mem_delay), .cfg_valid(cfg_valid), .cfg_data(cfg_data));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rchk(string nm, logic [ADDR_W-1:0] a, logic [31:0] m, logic [31:0] e);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(nm, e, rdata & m);
    endtask : rchk
    task automatic wake;
        @(posedge clk);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        @(negedge clk);
    endtask : wake
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic wait_loaded;
        n = 0;
        while (cfg_loaded !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            fails++;
            print_verdict();
        end
    endtask : wait_loaded
    task automatic do_reset(input logic p, input logic [CFG_W-1:0] w, input logic [3:0] dl);
        @(posedge clk);
        cfg_present <= p;
        mem_word    <= w;
        mem_delay   <= dl;
        reset       <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wait_loaded();
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, bus_reset, wr_en, rd_en, cfg_present, wake_event} = 6'h20;
        addr       = 8'h00;
        wdata      = 32'h0;
        mem_word   = 16'h0000;
        mem_delay  = 4'h2;
        fails      = 0;
        num_checks = 0;
        // list, skip, D2 wake, D2 support
        do_reset(1'b1, 16'hD400, 4'h2);
        rchk("cfg word", OFF_CFG_WORD, 32'h0000_FFFF, 32'h0000_D400);
        rchk("list flag", OFF_CFG_CMD_ST, 32'h0010_0000, 32'h0010_0000);
        rchk("id word", OFF_CAP_ID, 32'h3400_0000, 32'h2400_0000);
        rchk("pm cap", OFF_PM_CAP, 32'h0000_3400, 32'h0000_2400);
        rchk("skip copy", OFF_CHIP_PMC, 32'h0000_0008, 32'h0000_0008);
        rchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0);
        wr(OFF_CHIP_PMC, 32'h0000_0001);
        wr(OFF_PM_CTRL, 32'h0000_0102);
        chk("d2 state", 32'h2, {30'h0, power_state});
        wake();
        chk("d2 wake", 32'h1, {31'h0, pme_request});
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_STAT, 32'h0000_0001);
        chk("irq clear", 32'h0, {31'h0, irq});
        wr(OFF_PM_CTRL, 32'h0000_0103);
        wr(OFF_PM_CTRL, 32'h0000_0100);
        chk("skip wake", 32'h4, {28'h0, soft_reset, d0_initialized, power_state});
        rchk("ctx kept", OFF_CFG_WORD, 32'h0000_FFFF, 32'h0000_D400);
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
        @(negedge clk);
        chk("bus rst", 32'h0, {29'h0, d0_initialized, power_state});
        wait_loaded();
        rchk("pme kept", OFF_PM_CTRL, 32'h0000_8103, 32'h0000_8100);
        rchk("bus rst ev", OFF_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
        wr(OFF_PM_CTRL, 32'h0000_8100);
        rchk("pme clear", OFF_PM_CTRL, 32'h0000_8000, 32'h0);
        // D1 wake and support, no skip
        do_reset(1'b1, 16'h0A00, 4'h1);
        wr(OFF_PM_CTRL, 32'h0000_0102);
        chk("d2 refused", 32'h0, {30'h0, power_state});
        wr(OFF_PM_CTRL, 32'h0000_0101);
        wake();
        chk("d1 wake", 32'h1, {31'h0, pme_request});
        rchk("pm cap d1", OFF_PM_CAP, 32'h0000_3400, 32'h0000_1000);
        rchk("id d1", OFF_CAP_ID, 32'h3400_0000, 32'h1000_0000);
        rchk("no list", OFF_CFG_CMD_ST, 32'h0010_0000, 32'h0);
        rchk("no skip copy", OFF_CHIP_PMC, 32'h0000_0008, 32'h0);
        wr(OFF_PM_CTRL, 32'h0000_0103);
        wr(OFF_PM_CTRL, 32'h0000_0100);
        chk("soft rst", 32'h2, {30'h0, soft_reset, d0_initialized});
        n = 0;
        while (soft_reset === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk("srst len", SRST_CYCLES, n);
        wait_loaded();
        rchk("ctx lost", OFF_PM_CTRL, 32'h0000_0103, 32'h0);
        // both states supported, no wake bits
        do_reset(1'b1, 16'h0600, 4'h0);
        wr(OFF_PM_CTRL, 32'h0000_0101);
        wake();
        chk("no d1 wake", 32'h0, {31'h0, pme_request});
        wr(OFF_PM_CTRL, 32'h0000_0102);
        wake();
        chk("no d2 wake", 32'h0, {31'h0, pme_request});
        do_reset(1'b1, 16'hD400, 4'hF);
        rchk("timeout", OFF_CFG_WORD, 32'h0000_FFFF, {16'h0, CFG_DEFAULT});
        do_reset(1'b0, 16'hD400, 4'h2);
        rchk("no memory", OFF_CFG_WORD, 32'h0000_FFFF, {16'h0, CFG_DEFAULT});
        print_verdict();
    end
endmodule : tb_top
bind ppc_power_cap ppc_cap_mon #(.CFG_RESET_WORD(CFG_RESET_WORD)) ppc_cap_mon_inst (
    .clk(clk), .reset(reset), .bus_reset(bus_reset), .addr(addr), .rd_en(rd_en),
    .rdata(rdata), .cfg_req(cfg_req), .cfg_valid(cfg_valid), .cfg_data(cfg_data),
    .cfg_loaded(cfg_loaded), .pme_request(pme_request), .soft_reset(soft_reset),
    .power_state(power_state), .d0_initialized(d0_initialized));
`default_nettype wire
